// File: core/hsc_pkg.sv
package hsc_pkg;
	// register offsets
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_FAULT = 8'h04;
	localparam logic [7:0] ADDR_ILIM = 8'h11;
	localparam logic [7:0] ADDR_STATUS = 8'h1E;

	// control_config fields
	localparam int CTL_OV_RETRY = 0;
	localparam int CTL_UV_RETRY = 1;
	localparam int CTL_OC_RETRY = 2;
	localparam int CTL_GATE_EN = 3;
	localparam int CTL_FB_RETRY = 4;
	localparam int CTL_ON_HIGH = 5;
	localparam int CTL_ON_MASK = 7;

	// fault_record fields
	localparam int FLT_OV = 0;
	localparam int FLT_UV = 1;
	localparam int FLT_OC = 2;
	localparam int FLT_ON = 4;
	localparam int FLT_FB = 6;

	// status fields
	localparam int STS_PG = 0;
	localparam int STS_GATES = 1;
	localparam int STS_FAST = 2;
	localparam int STS_COOL = 3;

	// current limit field
	localparam int ILIM_HI = 7;
	localparam int ILIM_LO = 5;

	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_FAULT = 8'h00;
	localparam logic [7:0] RST_ILIM = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// fast shutdown qualification
	localparam int CLK_MHZ = 50;
	localparam int FAST_OFF_NS = 2000;
	localparam int FAST_OFF_CYC = (FAST_OFF_NS * CLK_MHZ) / 1000;
	localparam logic [7:0] FAST_OFF_MAX = 8'(FAST_OFF_CYC);

	// cool-down cycles after an overcurrent fault
	localparam logic [8:0] COOL_CYCLES = 9'h100;
	localparam logic [8:0] COOL_ONE = 9'h001;

	// analog comparator results, all asynchronous to clock
	typedef struct packed {
		logic on_pin;
		logic fb_above;
		logic vgs1_ok;
		logic vgs2_ok;
		logic ilim1;
		logic ilim2;
		logic timer_high;
		logic timer_low;
		logic vdd_ok;
		logic internal_supply_ok;
		logic ov_present;
		logic uv_present;
		logic fb_bad;
	} hsc_sense_t;

	// enables to the analog drivers
	typedef struct packed {
		logic first_gate_drive_up;
		logic second_gate_drive_up;
		logic weak_pulldown;
		logic strong_pulldown;
		logic timer_charge;
		logic timer_discharge;
	} hsc_drive_t;

	typedef enum logic [5:0] {
		TMR_IDLE = 6'b000001,
		TMR_BREAK = 6'b000010,
		TMR_OC_DOWN = 6'b000100,
		TMR_COOL_UP = 6'b001000,
		TMR_COOL_DN = 6'b010000,
		TMR_WAIT = 6'b100000
	} hsc_tmr_state_t;
endpackage : hsc_pkg

// File: core/hsc_turnoff_ctrl.sv
`timescale 1ns/1ps
module hsc_turnoff_ctrl (
	input wire logic clock,
	input wire logic arst_n,
	input wire hsc_pkg::hsc_sense_t sense,
	input wire logic [7:0] nvm_control,
	input wire logic [7:0] nvm_ilim,
	input wire logic pg_mode,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	output logic [7:0] reg_rdata,
	output hsc_pkg::hsc_drive_t drive,
	output logic [2:0] ilim_level,
	output logic pg_pin_o,
	output logic pg_pin_oe
);
	hsc_pkg::hsc_sense_t sync1;
	hsc_pkg::hsc_sense_t s;
	logic init_done;
	logic edge_arm1;
	logic edge_arm2;
	logic [7:0] control_config;
	logic [7:0] fault_record;
	logic [7:0] current_limit_select;
	logic on_prev;
	logic [7:0] fast_cnt;
	logic fast_off;
	logic [8:0] cool_cnt;
	hsc_pkg::hsc_tmr_state_t tmr_state;
	hsc_pkg::hsc_tmr_state_t next_tmr_state;
	logic on_level;
	logic on_edge;
	logic supply_low;
	logic both_limit;
	logic fault_block;
	logic latched;
	logic gates_on;
	logic power_good;
	logic oc_event;
	logic wr_ctl;
	logic wr_flt;
	logic wr_ilim;
	logic [7:0] fault_set;

	// two-stage synchroniser; the first stage feeds only the second
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sync1 <= '0;
			s <= '0;
		end else begin
			sync1 <= sense;
			s <= sync1;
		end
	end

	assign wr_ctl = reg_wr && (reg_addr == hsc_pkg::ADDR_CONTROL);
	assign wr_flt = reg_wr && (reg_addr == hsc_pkg::ADDR_FAULT);
	assign wr_ilim = reg_wr && (reg_addr == hsc_pkg::ADDR_ILIM);

	// asserted connection level follows the selected polarity
	assign on_level = control_config[hsc_pkg::CTL_ON_HIGH] ? s.on_pin : ~s.on_pin;
	assign on_edge = edge_arm2 && (s.on_pin != on_prev);
	assign supply_low = ~s.vdd_ok | ~s.internal_supply_ok;
	assign both_limit = s.ilim1 & s.ilim2;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			on_prev <= 1'b0;
		end else begin
			on_prev <= s.on_pin;
		end
	end

	// nonvolatile defaults are taken on the first edge after reset release,
	// since a flop under async reset may only take a constant
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			init_done <= 1'b0;
		end else begin
			init_done <= 1'b1;
		end
	end

	// the synchroniser and on_prev hold reset values for two edges after release;
	// an idle-high pin would otherwise look like a change and rewrite gate enable
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			edge_arm1 <= 1'b0;
			edge_arm2 <= 1'b0;
		end else begin
			edge_arm1 <= init_done;
			edge_arm2 <= edge_arm1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			control_config <= hsc_pkg::RST_CONTROL;
		end else if (!init_done) begin
			control_config <= nvm_control;
		end else if (on_edge) begin
			// connection edges win over a same-cycle host write of bit 3
			control_config <= wr_ctl ? reg_wdata : control_config;
			control_config[hsc_pkg::CTL_GATE_EN] <= on_level;
		end else if (wr_ctl) begin
			control_config <= reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			current_limit_select <= hsc_pkg::RST_ILIM;
		end else if (!init_done) begin
			current_limit_select <= nvm_ilim;
		end else if (wr_ilim) begin
			current_limit_select <= reg_wdata;
		end
	end

	assign ilim_level = current_limit_select[hsc_pkg::ILIM_HI:hsc_pkg::ILIM_LO];

	// fault events; a set in the same cycle as a clear wins
	always_comb begin
		fault_set = hsc_pkg::RST_ZERO;
		fault_set[hsc_pkg::FLT_OV] = s.ov_present;
		fault_set[hsc_pkg::FLT_UV] = s.uv_present;
		fault_set[hsc_pkg::FLT_OC] = oc_event;
		fault_set[hsc_pkg::FLT_FB] = s.fb_bad;
		fault_set[hsc_pkg::FLT_ON] = on_edge;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fault_record <= hsc_pkg::RST_FAULT;
		end else if (on_edge && !control_config[hsc_pkg::CTL_ON_MASK]) begin
			fault_record <= fault_set;
		end else if (wr_flt) begin
			fault_record <= reg_wdata | fault_set;
		end else begin
			fault_record <= fault_record | fault_set;
		end
	end

	// faults whose retry bit is clear hold the gates off until the bit is cleared
	assign latched =
		(fault_record[hsc_pkg::FLT_OV] & ~control_config[hsc_pkg::CTL_OV_RETRY]) |
		(fault_record[hsc_pkg::FLT_UV] & ~control_config[hsc_pkg::CTL_UV_RETRY]) |
		(fault_record[hsc_pkg::FLT_OC] & ~control_config[hsc_pkg::CTL_OC_RETRY]) |
		(fault_record[hsc_pkg::FLT_FB] & ~control_config[hsc_pkg::CTL_FB_RETRY]);

	assign fault_block = s.ov_present | s.uv_present | s.fb_bad | oc_event |
		(tmr_state != hsc_pkg::TMR_IDLE && tmr_state != hsc_pkg::TMR_BREAK);

	// fast shutdown qualification; strictly more than the window must pass
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fast_cnt <= hsc_pkg::RST_ZERO;
			fast_off <= 1'b0;
		end else if (!supply_low) begin
			fast_cnt <= hsc_pkg::RST_ZERO;
			fast_off <= 1'b0;
		end else if (fast_cnt < hsc_pkg::FAST_OFF_MAX) begin
			fast_cnt <= fast_cnt + 8'h01;
		end else begin
			fast_off <= 1'b1;
		end
	end

	assign gates_on = init_done && control_config[hsc_pkg::CTL_GATE_EN] && !latched &&
		!fault_block && !fast_off;

	// circuit-breaker timer sequencing
	always_comb begin
		next_tmr_state = tmr_state;
		oc_event = 1'b0;
		case (tmr_state)
			hsc_pkg::TMR_IDLE: begin
				if (both_limit) begin
					next_tmr_state = hsc_pkg::TMR_BREAK;
				end
			end
			hsc_pkg::TMR_BREAK: begin
				if (both_limit && s.timer_high) begin
					oc_event = 1'b1;
					next_tmr_state = hsc_pkg::TMR_OC_DOWN;
				end else if (!both_limit) begin
					next_tmr_state = hsc_pkg::TMR_IDLE;
				end
			end
			hsc_pkg::TMR_OC_DOWN: begin
				if (s.timer_low) begin
					next_tmr_state = hsc_pkg::TMR_COOL_UP;
				end
			end
			hsc_pkg::TMR_COOL_UP: begin
				if (s.timer_high) begin
					next_tmr_state = hsc_pkg::TMR_COOL_DN;
				end
			end
			hsc_pkg::TMR_COOL_DN: begin
				if (s.timer_low) begin
					if (cool_cnt == hsc_pkg::COOL_CYCLES) begin
						next_tmr_state = hsc_pkg::TMR_WAIT;
					end else begin
						next_tmr_state = hsc_pkg::TMR_COOL_UP;
					end
				end
			end
			hsc_pkg::TMR_WAIT: begin
				if (control_config[hsc_pkg::CTL_OC_RETRY] ||
					!fault_record[hsc_pkg::FLT_OC]) begin
					next_tmr_state = hsc_pkg::TMR_IDLE;
				end
			end
			default: begin
				next_tmr_state = hsc_pkg::TMR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tmr_state <= hsc_pkg::TMR_IDLE;
		end else begin
			tmr_state <= next_tmr_state;
		end
	end

	// counts completed rises of the cool-down, each on timer_high in TMR_COOL_UP
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cool_cnt <= 9'h000;
		end else if (tmr_state == hsc_pkg::TMR_OC_DOWN) begin
			cool_cnt <= 9'h000;
		end else if (tmr_state == hsc_pkg::TMR_COOL_UP && s.timer_high) begin
			cool_cnt <= cool_cnt + hsc_pkg::COOL_ONE;
		end
	end

	// a power-bad fault is never raised here, so feedback rising before the
	// gate threshold during start-up records nothing
	assign power_good = gates_on && s.fb_above && (s.vgs1_ok || s.vgs2_ok);

	// driver enables registered so analog side sees glitch-free levels
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			drive <= '0;
			pg_pin_oe <= 1'b0;
			reg_rdata <= hsc_pkg::RST_ZERO;
		end else begin
			// both channels follow gates_on together; regulation of a limiting
			// channel is done by the analog loop
			drive.first_gate_drive_up <= gates_on;
			drive.second_gate_drive_up <= gates_on;
			drive.weak_pulldown <= !gates_on && !fast_off;
			drive.strong_pulldown <= fast_off;
			drive.timer_charge <= (next_tmr_state == hsc_pkg::TMR_BREAK) ||
				(next_tmr_state == hsc_pkg::TMR_COOL_UP);
			drive.timer_discharge <= (next_tmr_state != hsc_pkg::TMR_BREAK) &&
				(next_tmr_state != hsc_pkg::TMR_COOL_UP);
			pg_pin_oe <= pg_mode && !power_good;
			case (reg_addr)
				hsc_pkg::ADDR_CONTROL: reg_rdata <= control_config;
				hsc_pkg::ADDR_FAULT: reg_rdata <= fault_record;
				hsc_pkg::ADDR_ILIM: reg_rdata <= current_limit_select;
				hsc_pkg::ADDR_STATUS: begin
					reg_rdata <= hsc_pkg::RST_ZERO;
					reg_rdata[hsc_pkg::STS_PG] <= power_good;
					reg_rdata[hsc_pkg::STS_GATES] <= gates_on;
					reg_rdata[hsc_pkg::STS_FAST] <= fast_off;
					reg_rdata[hsc_pkg::STS_COOL] <= (tmr_state != hsc_pkg::TMR_IDLE) &&
						(tmr_state != hsc_pkg::TMR_BREAK);
				end
				default: reg_rdata <= hsc_pkg::RST_ZERO;
			endcase
		end
	end

	// open-drain: only ever pulls low
	assign pg_pin_o = 1'b0;
endmodule : hsc_turnoff_ctrl

// File: dv/hsc_timer_model.sv
`timescale 1ns/1ps
module hsc_timer_model #(
	parameter int HIGH = 32
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic charge,
	input wire logic discharge,
	output logic high,
	output logic low
);
	int lvl;
	// charge step is four discharge steps, as 20uA against 5uA; level holds when idle
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			lvl <= 0;
		else if (charge && lvl < HIGH + 8)
			lvl <= lvl + 4;
		else if (discharge && lvl > 0)
			lvl <= lvl - 1;
	end
	assign high = lvl >= HIGH;
	assign low = lvl <= 2;
endmodule : hsc_timer_model

// File: dv/hsc_turnoff_ctrl_chk.sv
`timescale 1ns/1ps
module hsc_turnoff_ctrl_chk (
	input wire logic clock,
	input wire logic arst_n,
	input wire hsc_pkg::hsc_sense_t sense,
	input wire logic [7:0] nvm_control,
	input wire logic [7:0] nvm_ilim,
	input wire logic pg_mode,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [7:0] reg_rdata,
	input wire hsc_pkg::hsc_drive_t drive,
	input wire logic [2:0] ilim_level,
	input wire logic pg_pin_o,
	input wire logic pg_pin_oe
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic [7:0] low_cnt;
	wire both_lim = sense.ilim1 & sense.ilim2;
	// saturates so a long brown-out cannot wrap below the limit
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			low_cnt <= 8'h00;
		else if (sense.vdd_ok && sense.internal_supply_ok)
			low_cnt <= 8'h00;
		else if (low_cnt != 8'hFF)
			low_cnt <= low_cnt + 8'h01;
	end
	a_pull_excl: assert property (!(drive.weak_pulldown && drive.first_gate_drive_up))
		else $error("weak pull-down while gate on");
	a_gates_pair: assert property (drive.first_gate_drive_up == drive.second_gate_drive_up)
		else $error("gate drives differ");
	a_strong_off: assert property (drive.strong_pulldown |->
		!drive.first_gate_drive_up && !drive.weak_pulldown) else $error("strong pull-down with gate on");
	a_fast_qual: assert property ($rose(drive.strong_pulldown) |->
		low_cnt >= hsc_pkg::FAST_OFF_MAX) else $error("fast shutdown too early");
	a_fast_clear: assert property ((sense.vdd_ok && sense.internal_supply_ok) [*5] |->
		!drive.strong_pulldown) else $error("fast shutdown kept after recovery");
	a_charge_both: assert property (drive.timer_charge && drive.first_gate_drive_up |->
		$past(both_lim, 2) || $past(both_lim, 3) || $past(both_lim, 4))
		else $error("timer charged without both limits");
	a_timer_excl: assert property (!(drive.timer_charge && drive.timer_discharge))
		else $error("timer charge and discharge together");
	a_pg_good: assert property ($past(pg_mode) && $past(arst_n) && !pg_pin_oe |->
		drive.first_gate_drive_up) else $error("power good with gates off");
	a_pg_pull: assert property ($past(pg_mode) && $past(arst_n) && !drive.first_gate_drive_up |->
		pg_pin_oe) else $error("power-good pin released with gates off");
	a_rd_ilim: assert property ($past(arst_n, 2) && $past(reg_addr) == hsc_pkg::ADDR_ILIM
		&& !$past(reg_wr) |-> reg_rdata[7:5] == ilim_level) else $error("limit field differs");
	a_gate_wr: assert property (reg_wr && reg_addr == hsc_pkg::ADDR_CONTROL && $past(arst_n)
		&& !reg_wdata[hsc_pkg::CTL_GATE_EN] |-> ##2 !drive.first_gate_drive_up)
		else $error("gates on after gate enable cleared");
endmodule : hsc_turnoff_ctrl_chk

// File: dv/tb_hsc_turnoff_ctrl.sv
`timescale 1ns/1ps
module tb_hsc_turnoff_ctrl;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	hsc_pkg::hsc_sense_t sns, sense;
	hsc_pkg::hsc_drive_t drive;
	logic [7:0] nvm_control, nvm_ilim, reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, pg_mode, pg_pin_o, pg_pin_oe, t_hi, t_lo, prev;
	logic [2:0] ilim_level;
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;
	int seed = 96245;
	int n;
	int src[3] = '{2, 1, 0};
	int flt[3] = '{hsc_pkg::FLT_OV, hsc_pkg::FLT_UV, hsc_pkg::FLT_FB};
	int rty[3] = '{hsc_pkg::CTL_OV_RETRY, hsc_pkg::CTL_UV_RETRY, hsc_pkg::CTL_FB_RETRY};
	hsc_turnoff_ctrl i_dut (.clock, .arst_n, .sense, .nvm_control, .nvm_ilim, .pg_mode,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .drive, .ilim_level, .pg_pin_o, .pg_pin_oe);
	hsc_timer_model i_cap (.clock, .arst_n, .charge(drive.timer_charge),
		.discharge(drive.timer_discharge), .high(t_hi), .low(t_lo));
	initial forever #10 clock = ~clock;
	always_comb begin
		sense = sns;
		sense.timer_high = t_hi;
		sense.timer_low = t_lo;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wt(input int c);
		repeat (c) @(posedge clock);
		#1;
	endtask : wt
	task automatic set(input int b, input logic v);
		@(posedge clock);
		sns[b] <= v;
	endtask : set
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		wt(1);
		chk(16'(reg_rdata & m), 16'(e));
	endtask : rd
	task automatic gates(input logic e);
		chk(16'({drive.first_gate_drive_up, drive.second_gate_drive_up, drive.weak_pulldown}), e ? 16'h0006 : 16'h0001);
	endtask : gates
	initial begin
		sns = '0;
		sns.vdd_ok = 1'b1;
		sns.internal_supply_ok = 1'b1;
		nvm_control = 8'($random(seed));
		nvm_ilim = 8'($random(seed));
		pg_mode = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		wt(4);
		arst_n <= 1'b1;
		wt(3);
		rd(hsc_pkg::ADDR_CONTROL, 8'hFF, nvm_control);
		rd(hsc_pkg::ADDR_ILIM, 8'hFF, nvm_ilim);
		chk(16'(ilim_level), 16'(nvm_ilim[7:5]));
		rd(8'h20 | 8'($random(seed) & 8'h1F), 8'hFF, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(hsc_pkg::ADDR_ILIM, {3'(i), 5'($random(seed))});
			wt(1);
			chk(16'(ilim_level), 16'(i));
		end
		$display("test limit select done");
		for (int k = 0; k < 3; k++) begin
			for (int r = 0; r < 2; r++) begin
				wr(hsc_pkg::ADDR_CONTROL, 8'h08 | 8'(r << rty[k]));
				wt(6);
				gates(1'b1);
				set(src[k], 1'b1);
				wt(6);
				gates(1'b0);
				set(src[k], 1'b0);
				wt(6);
				gates(r[0]);
				rd(hsc_pkg::ADDR_FAULT, 8'hFF, 8'(1 << flt[k]));
				wr(hsc_pkg::ADDR_FAULT, 8'h00);
				wt(4);
				gates(1'b1);
			end
		end
		$display("test faults done");
		for (int p = 0; p < 2; p++) begin
			// second pass also masks the fault clear on connection edges
			wr(hsc_pkg::ADDR_CONTROL, 8'(p << hsc_pkg::CTL_ON_HIGH) | 8'(p << hsc_pkg::CTL_ON_MASK));
			set(12, !p[0]);
			wt(8);
			wr(hsc_pkg::ADDR_FAULT, 8'h01);
			wt(2);
			set(12, p[0]);
			wt(8);
			gates(!p[0]);
			rd(hsc_pkg::ADDR_FAULT, 8'hFF, 8'h10 | 8'(p));
			rd(hsc_pkg::ADDR_CONTROL, 8'h08, 8'h08);
			set(12, !p[0]);
			wt(8);
			gates(1'b0);
			rd(hsc_pkg::ADDR_CONTROL, 8'h08, 8'h00);
		end
		wr(hsc_pkg::ADDR_FAULT, 8'h00);
		wr(hsc_pkg::ADDR_CONTROL, 8'h08);
		$display("test connection input done");
		for (int s = 4; s > 2; s--) begin
			set(s, 1'b0);
			wt(60);
			set(s, 1'b1);
			set(s, 1'b0);
			wt(60);
			chk(16'(drive.strong_pulldown), 16'h0000);
			wt(50);
			chk(16'({drive.first_gate_drive_up, drive.weak_pulldown, drive.strong_pulldown}), 16'h0001);
			set(s, 1'b1);
			wt(6);
			gates(1'b1);
		end
		$display("test fast shutdown done");
		for (int r = 0; r < 2; r++) begin
			wr(hsc_pkg::ADDR_CONTROL, 8'h08 | 8'(r << hsc_pkg::CTL_OC_RETRY));
			set(8, 1'b1);
			wt(10);
			chk(16'(drive.timer_charge), 16'h0000);
			gates(1'b1);
			set(7, 1'b1);
			wt(2);
			set(7, 1'b0);
			wt(5);
			chk(16'({drive.timer_charge, drive.timer_discharge}), 16'h0001);
			gates(1'b1);
			set(7, 1'b1);
			for (int i = 0; i < 100 && drive.first_gate_drive_up !== 1'b0; i++)
				wt(1);
			gates(1'b0);
			set(8, 1'b0);
			set(7, 1'b0);
			// first pass clears early: turn-on must still wait for the last fall;
			// second pass keeps the bit and relies on auto-retry instead
			if (r == 0)
				wr(hsc_pkg::ADDR_FAULT, 8'h00);
			n = 0;
			prev = 1'b1;
			for (int i = 0; i < 30000 && drive.first_gate_drive_up !== 1'b1; i++) begin
				wt(1);
				if (drive.timer_charge && !prev)
					n++;
				prev = drive.timer_charge;
			end
			chk(16'(n), 16'(hsc_pkg::COOL_CYCLES));
			gates(1'b1);
			rd(hsc_pkg::ADDR_FAULT, 8'h04, 8'(r << hsc_pkg::FLT_OC));
		end
		wr(hsc_pkg::ADDR_FAULT, 8'h00);
		$display("test overcurrent done");
		set(11, 1'b1);
		wt(6);
		chk(16'(pg_pin_oe), 16'h0001);
		rd(hsc_pkg::ADDR_FAULT, 8'hFF, 8'h00);
		set(10, 1'b1);
		wt(6);
		chk(16'(pg_pin_oe), 16'h0000);
		rd(hsc_pkg::ADDR_STATUS, 8'h01, 8'h01);
		set(11, 1'b0);
		wt(6);
		chk(16'({pg_pin_oe, pg_pin_o}), 16'h0002);
		@(posedge clock);
		pg_mode <= 1'b0;
		wt(3);
		chk(16'(pg_pin_oe), 16'h0000);
		$display("test power good done");
		close_out();
	end
endmodule : tb_hsc_turnoff_ctrl
bind hsc_turnoff_ctrl hsc_turnoff_ctrl_chk i_chk (.clock, .arst_n, .sense, .nvm_control,
	.nvm_ilim, .pg_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .drive, .ilim_level,
	.pg_pin_o, .pg_pin_oe);
